// ===== common/rmlm_pkg.sv
// constants and types shared by the regulator mask / load meter block
`default_nettype none
package rmlm_pkg;
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 8;
    localparam int          NUM_REG          = 4;
    localparam int          IDX_W            = 2;
    localparam int          RES_W            = 10;
    localparam int          NUM_FLAG         = 5;

    localparam logic [7:0]  ADDR_MASK_2_3    = 8'h24;
    localparam logic [7:0]  ADDR_MEAS_SEL    = 8'h25;
    localparam logic [7:0]  ADDR_RES_HIGH    = 8'h26;
    localparam logic [7:0]  ADDR_RES_LOW     = 8'h27;
    localparam logic [7:0]  ADDR_PG_SRC      = 8'h28;

    localparam logic [7:0]  MASK_2_3_RST     = 8'h00;
    localparam logic [7:0]  MASK_2_3_WR_BITS = 8'hDD;
    localparam logic [7:0]  MEAS_SEL_RST     = 8'h00;
    localparam logic [7:0]  PG_SRC_RST       = 8'h00;
    localparam logic [9:0]  RESULT_RST       = 10'h000;
    localparam logic [9:0]  RESULT_MAX       = 10'h3FF;

    localparam int          BIT_REG2_LIMIT_BLK = 0;
    localparam int          BIT_REG2_GOOD_BLK  = 2;
    localparam int          BIT_REG3_LIMIT_BLK = 4;
    localparam int          BIT_REG3_GOOD_BLK  = 6;
    localparam int          SEL_LSB            = 0;
    localparam int          RES_HIGH_LSB       = 8;
    localparam int          PG_SRC_W           = 2;

    localparam int          FLG_REG2_LIMIT   = 0;
    localparam int          FLG_REG2_GOOD    = 1;
    localparam int          FLG_REG3_LIMIT   = 2;
    localparam int          FLG_REG3_GOOD    = 3;
    localparam int          FLG_LOAD_READY   = 4;

    localparam int          REG2             = 2;
    localparam int          REG3             = 3;

    localparam logic [1:0]  PG_SRC_OFF       = 2'h0;
    localparam logic [1:0]  PG_SRC_VOLT      = 2'h1;
    localparam logic [1:0]  PG_SRC_RSVD      = 2'h2;
    localparam logic [1:0]  PG_SRC_VOLT_ILIM = 2'h3;

    localparam logic [1:0]  IDX_LAST         = 2'h3;
    localparam logic [1:0]  IDX_FIRST        = 2'h0;

    typedef enum logic [1:0] {
        RMLM_IDLE = 2'b00,
        RMLM_SCAN = 2'b01,
        RMLM_WAIT = 2'b11,
        RMLM_DONE = 2'b10
    } rmlm_state_t;
endpackage : rmlm_pkg
`default_nettype wire

// ===== design/rmlm_meter.sv
// load-current measurement sequencer: scans the selected phases and sums their samples
`default_nettype none
module rmlm_meter (
    input  wire logic                             core_clk,
    input  wire logic                             arst_n,
    input  wire logic                             start,
    input  wire logic [rmlm_pkg::IDX_W-1:0]       sel,
    input  wire logic [2*rmlm_pkg::NUM_REG-1:0]   master_of,
    output logic                                  sense_req,
    output logic [rmlm_pkg::IDX_W-1:0]            sense_idx,
    input  wire logic                             sense_ack,
    input  wire logic [rmlm_pkg::RES_W-1:0]       sense_data,
    output logic                                  done,
    output logic [rmlm_pkg::RES_W-1:0]            result
);
    import rmlm_pkg::*;

    rmlm_state_t            state_ff, nxt_state;
    logic [IDX_W-1:0]       idx_ff, nxt_idx;
    logic [NUM_REG-1:0]     incl_ff, nxt_incl;
    logic [RES_W-1:0]       acc_ff, nxt_acc;
    logic [RES_W-1:0]       result_ff, nxt_result;
    logic                   req_ff, nxt_req;
    logic                   done_ff, nxt_done;

    function automatic logic [IDX_W-1:0] owner(input logic [2*NUM_REG-1:0] map, input int i);
        owner = map[i*IDX_W +: IDX_W];
    endfunction

    // saturate rather than wrap: a wrapped sum would read as a light load
    function automatic logic [RES_W-1:0] sat_add(input logic [RES_W-1:0] a, input logic [RES_W-1:0] b);
        logic [RES_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[RES_W] ? RESULT_MAX : s[RES_W-1:0];
    endfunction

    always_comb begin
        nxt_state  = state_ff;
        nxt_idx    = idx_ff;
        nxt_incl   = incl_ff;
        nxt_acc    = acc_ff;
        nxt_result = result_ff;
        nxt_req    = 1'b0;
        nxt_done   = 1'b0;
        if (start) begin
            nxt_state = RMLM_SCAN;
            nxt_idx   = IDX_FIRST;
            nxt_acc   = RESULT_RST;
            for (int j = 0; j < NUM_REG; j++) begin
                // master: itself and all phases it owns; slave: only itself
                nxt_incl[j] = (IDX_W'(j) == sel) ||
                              ((owner(master_of, int'(sel)) == sel) && (owner(master_of, j) == sel));
            end
        end else begin
            case (state_ff)
                RMLM_IDLE: begin
                    nxt_state = RMLM_IDLE;
                end
                RMLM_SCAN: begin
                    if (incl_ff[idx_ff]) begin
                        nxt_req   = 1'b1;
                        nxt_state = RMLM_WAIT;
                    end else if (idx_ff == IDX_LAST) begin
                        nxt_state = RMLM_DONE;
                    end else begin
                        nxt_idx = idx_ff + IDX_W'(1);
                    end
                end
                RMLM_WAIT: begin
                    if (sense_ack) begin
                        nxt_acc = sat_add(acc_ff, sense_data);
                        if (idx_ff == IDX_LAST) begin
                            nxt_state = RMLM_DONE;
                        end else begin
                            nxt_idx   = idx_ff + IDX_W'(1);
                            nxt_state = RMLM_SCAN;
                        end
                    end
                end
                RMLM_DONE: begin
                    nxt_result = acc_ff;
                    nxt_done   = 1'b1;
                    nxt_state  = RMLM_IDLE;
                end
                default: begin
                    nxt_state = RMLM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff  <= RMLM_IDLE;
            idx_ff    <= IDX_FIRST;
            incl_ff   <= '0;
            acc_ff    <= RESULT_RST;
            result_ff <= RESULT_RST;
            req_ff    <= 1'b0;
            done_ff   <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            idx_ff    <= nxt_idx;
            incl_ff   <= nxt_incl;
            acc_ff    <= nxt_acc;
            result_ff <= nxt_result;
            req_ff    <= nxt_req;
            done_ff   <= nxt_done;
        end
    end

    assign sense_req = req_ff;
    assign sense_idx = idx_ff;
    assign done      = done_ff;
    assign result    = result_ff;
endmodule // rmlm_meter
`default_nettype wire

// ===== design/rmlm_top.sv
// register bank for regulator 2/3 masks, load-current meter and power-good source select
`default_nettype none
module rmlm_top (
    input  wire logic                             core_clk,
    input  wire logic                             arst_n,
    input  wire logic [rmlm_pkg::ADDR_W-1:0]      reg_addr,
    input  wire logic [rmlm_pkg::DATA_W-1:0]      reg_wdata,
    input  wire logic                             reg_wr,
    input  wire logic                             reg_rd,
    output logic [rmlm_pkg::DATA_W-1:0]           reg_rdata,
    output logic                                  reg_rvalid,
    input  wire logic [rmlm_pkg::NUM_REG-1:0]     reg_good_raw,
    input  wire logic [rmlm_pkg::NUM_REG-1:0]     reg_limit_raw,
    input  wire logic [2*rmlm_pkg::NUM_REG-1:0]   phase_master_of,
    input  wire logic                             load_ready_irq_block,
    input  wire logic [rmlm_pkg::NUM_FLAG-1:0]    irq_flag_clear,
    output logic [rmlm_pkg::NUM_FLAG-1:0]         irq_flags,
    output logic                                  irq_request,
    output logic                                  combined_power_ok_output,
    output logic                                  sense_req,
    output logic [rmlm_pkg::IDX_W-1:0]            sense_idx,
    input  wire logic                             sense_ack,
    input  wire logic [rmlm_pkg::RES_W-1:0]       sense_data
);
    import rmlm_pkg::*;

    logic [DATA_W-1:0]      mask_ff, nxt_mask;
    logic [DATA_W-1:0]      sel_ff, nxt_sel;
    logic [DATA_W-1:0]      pg_src_ff, nxt_pg_src;
    logic [RES_W-1:0]       res_ff, nxt_res;
    logic [DATA_W-1:0]      rdata_ff, nxt_rdata;
    logic                   rvalid_ff, nxt_rvalid;
    logic [NUM_FLAG-1:0]    flag_ff, nxt_flag;
    logic [NUM_REG-1:0]     good_prev_ff, limit_prev_ff;
    logic                   irq_ff, nxt_irq;
    logic                   pok_ff, nxt_pok;
    logic                   meas_start;
    logic                   meas_done;
    logic [RES_W-1:0]       meas_result;
    logic [NUM_FLAG-1:0]    flag_set;
    logic [NUM_FLAG-1:0]    flag_block;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        addr_hit = (a == off);
    endfunction

    // reserved code 2 is taken like code 1 so a bad write cannot hide a failed regulator from the output
    function automatic logic pg_term(input logic [1:0] src, input logic good, input logic limit);
        case (src)
            PG_SRC_OFF:       pg_term = 1'b1;
            PG_SRC_VOLT:      pg_term = good;
            PG_SRC_RSVD:      pg_term = good;
            PG_SRC_VOLT_ILIM: pg_term = good & ~limit;
            default:          pg_term = 1'b1;
        endcase
    endfunction

    // register writes
    always_comb begin
        nxt_mask   = mask_ff;
        nxt_sel    = sel_ff;
        nxt_pg_src = pg_src_ff;
        meas_start = 1'b0;
        if (reg_wr) begin
            if (addr_hit(reg_addr, ADDR_MASK_2_3)) begin
                nxt_mask = reg_wdata & MASK_2_3_WR_BITS;
            end
            if (addr_hit(reg_addr, ADDR_MEAS_SEL)) begin
                nxt_sel    = reg_wdata;
                meas_start = 1'b1;
            end
            if (addr_hit(reg_addr, ADDR_PG_SRC)) begin
                nxt_pg_src = reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_ff   <= MASK_2_3_RST;
            sel_ff    <= MEAS_SEL_RST;
            pg_src_ff <= PG_SRC_RST;
        end else begin
            mask_ff   <= nxt_mask;
            sel_ff    <= nxt_sel;
            pg_src_ff <= nxt_pg_src;
        end
    end

    rmlm_meter u_meter (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .start      (meas_start),
        .sel        (reg_wdata[SEL_LSB +: IDX_W]),
        .master_of  (phase_master_of),
        .sense_req  (sense_req),
        .sense_idx  (sense_idx),
        .sense_ack  (sense_ack),
        .sense_data (sense_data),
        .done       (meas_done),
        .result     (meas_result)
    );

    // result holds the last finished measurement, in 20 mA steps
    always_comb begin
        nxt_res = res_ff;
        if (meas_done) begin
            nxt_res = meas_result;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            res_ff <= RESULT_RST;
        end else begin
            res_ff <= nxt_res;
        end
    end

    // register reads, answered one cycle later
    always_comb begin
        nxt_rvalid = reg_rd;
        nxt_rdata  = rdata_ff;
        if (reg_rd) begin
            if (addr_hit(reg_addr, ADDR_MASK_2_3)) begin
                nxt_rdata = mask_ff;
            end else if (addr_hit(reg_addr, ADDR_MEAS_SEL)) begin
                nxt_rdata = sel_ff;
            end else if (addr_hit(reg_addr, ADDR_RES_HIGH)) begin
                nxt_rdata = {{(DATA_W-(RES_W-RES_HIGH_LSB)){1'b0}}, res_ff[RES_W-1:RES_HIGH_LSB]};
            end else if (addr_hit(reg_addr, ADDR_RES_LOW)) begin
                nxt_rdata = res_ff[RES_HIGH_LSB-1:0];
            end else if (addr_hit(reg_addr, ADDR_PG_SRC)) begin
                nxt_rdata = pg_src_ff;
            end else begin
                nxt_rdata = '0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff  <= '0;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // event flags: limit on onset, power-good on any change; raw inputs are never altered
    always_comb begin
        flag_set                 = '0;
        flag_set[FLG_REG2_LIMIT] = reg_limit_raw[REG2] & ~limit_prev_ff[REG2];
        flag_set[FLG_REG3_LIMIT] = reg_limit_raw[REG3] & ~limit_prev_ff[REG3];
        flag_set[FLG_REG2_GOOD]  = reg_good_raw[REG2] ^ good_prev_ff[REG2];
        flag_set[FLG_REG3_GOOD]  = reg_good_raw[REG3] ^ good_prev_ff[REG3];
        flag_set[FLG_LOAD_READY] = meas_done;
        // a set in the same cycle as a clear wins, so no event is lost
        nxt_flag = (flag_ff & ~irq_flag_clear) | flag_set;
    end

    always_comb begin
        flag_block                 = '0;
        flag_block[FLG_REG2_LIMIT] = mask_ff[BIT_REG2_LIMIT_BLK];
        flag_block[FLG_REG2_GOOD]  = mask_ff[BIT_REG2_GOOD_BLK];
        flag_block[FLG_REG3_LIMIT] = mask_ff[BIT_REG3_LIMIT_BLK];
        flag_block[FLG_REG3_GOOD]  = mask_ff[BIT_REG3_GOOD_BLK];
        flag_block[FLG_LOAD_READY] = load_ready_irq_block;
        nxt_irq = |(nxt_flag & ~flag_block);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_ff       <= '0;
            good_prev_ff  <= '0;
            limit_prev_ff <= '0;
            irq_ff        <= 1'b0;
        end else begin
            flag_ff       <= nxt_flag;
            good_prev_ff  <= reg_good_raw;
            limit_prev_ff <= reg_limit_raw;
            irq_ff        <= nxt_irq;
        end
    end

    // combined power-ok: and of the per-regulator terms
    always_comb begin
        nxt_pok = 1'b1;
        for (int i = 0; i < NUM_REG; i++) begin
            nxt_pok = nxt_pok & pg_term(pg_src_ff[i*PG_SRC_W +: PG_SRC_W], reg_good_raw[i], reg_limit_raw[i]);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pok_ff <= 1'b0;
        end else begin
            pok_ff <= nxt_pok;
        end
    end

    assign reg_rdata                = rdata_ff;
    assign reg_rvalid               = rvalid_ff;
    assign irq_flags                = flag_ff;
    assign irq_request              = irq_ff;
    assign combined_power_ok_output = pok_ff;
endmodule // rmlm_top
`default_nettype wire

// ===== sim/regulator_mask_load_meter_pg_select_bench.sv
// self-checking bench for the regulator mask / load meter block
`default_nettype none
module regulator_mask_load_meter_pg_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rmlm_pkg::*;
    logic        core_clk, arst_n, reg_wr, reg_rd, reg_rvalid, load_ready_irq_block, slow;
    logic        irq_request, combined_power_ok_output, sense_req, sense_ack;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, phase_master_of;
    logic [3:0]  reg_good_raw, reg_limit_raw;
    logic [4:0]  irq_flag_clear, irq_flags;
    logic [1:0]  sense_idx;
    logic [9:0]  sense_data;
    logic [39:0] cur_flat;
    logic [7:0]  exp_q[$];
    int          mismatches, samples_checked, seed, sum;
    rmlm_top u_dut (.*);
    rmlm_sensor u_sensor (.*);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 8'($random(seed)));
    endtask
    function automatic void chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endfunction
    task automatic wait_ready();
        int n;
        n = 0;
        while (irq_flags[FLG_LOAD_READY] !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        chk(n < 200, 1'b1);
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // read data is judged against the oldest note when it appears
    always @(posedge core_clk) begin
        if (reg_rvalid === 1'b1) chk(reg_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
    end
    initial begin : watchdog
        repeat (6000) @(posedge core_clk);
        mismatches++;
        report_and_stop();
    end
    initial begin : main
        logic [7:0]  d;
        logic [3:0]  g, l;
        logic [39:0] cv;
        logic [7:0]  cfg [3];
        cfg = '{8'hE4, 8'h00, 8'hA0};
        seed = 23532;
        {arst_n, reg_wr, reg_rd, load_ready_irq_block, slow, cur_flat} = '0;
        {reg_addr, reg_wdata, phase_master_of, reg_good_raw, reg_limit_raw, irq_flag_clear} = '0;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        for (int a = 8'h24; a < 8'h2B; a++) rd(8'(a), 8'h00);
        bus(1'b1, 1'b0, 8'h29, 8'hFF);
        bus(1'b1, 1'b0, ADDR_MASK_2_3, 8'hFF);
        bus(1'b1, 1'b0, ADDR_PG_SRC, 8'hD7);
        rd(ADDR_MASK_2_3, MASK_2_3_WR_BITS);
        rd(8'h29, 8'h00);
        rd(ADDR_PG_SRC, 8'hD7);
        idle(2);
        $display("register map test done");
        for (int i = 0; i < 4; i++) begin
            for (int m = 0; m < 2; m++) begin
                bus(1'b1, 1'b0, ADDR_MASK_2_3, 8'(m << (2 * i)));
                idle(1);
                if (i[0]) reg_good_raw[REG2 + i / 2] <= ~reg_good_raw[REG2 + i / 2];
                else reg_limit_raw[REG2 + i / 2] <= 1'b1;
                idle(3);
                chk(irq_flags[i], 1'b1);
                chk(irq_request, m == 0);
                reg_limit_raw <= 4'h0;
                idle(3);
                irq_flag_clear <= 5'h1F;
                idle(1);
                irq_flag_clear <= 5'h00;
                idle(2);
                chk(irq_flags, 5'h00);
            end
        end
        $display("interrupt mask test done");
        for (int i = 0; i < 4; i++) begin
            for (int c = 0; c < 4; c++) begin
                if (c == 2) continue; // reserved source code is never programmed
                bus(1'b1, 1'b0, ADDR_PG_SRC, 8'(c << (2 * i)));
                for (int k = 0; k < 4; k++) begin
                    g = 4'($random(seed));
                    l = 4'($random(seed));
                    g[i] = k[0];
                    l[i] = k[1];
                    reg_good_raw <= g;
                    reg_limit_raw <= l;
                    idle(2);
                    chk(combined_power_ok_output, c == 0 || (k[0] && (c == 1 || !k[1])));
                end
            end
        end
        $display("power ok test done");
        bus(1'b1, 1'b0, ADDR_MASK_2_3, 8'hFF);
        for (int f = 0; f < 3; f++) begin
            for (int s = 0; s < 4; s++) begin
                cv = 40'({$random(seed), $random(seed)});
                cur_flat <= cv;
                phase_master_of <= cfg[f];
                slow <= s[0];
                load_ready_irq_block <= 1'($random(seed));
                irq_flag_clear <= 5'h1F;
                idle(1);
                irq_flag_clear <= 5'h00;
                sum = 0;
                for (int j = 0; j < 4; j++) begin
                    if (j == s || (cfg[f][2*s +: 2] == s && cfg[f][2*j +: 2] == s)) sum += cv[10*j +: 10];
                end
                if (sum > 1023) sum = 1023;
                d = {6'($random(seed)), 2'(s)};
                bus(1'b1, 1'b0, ADDR_MEAS_SEL, d ^ 8'h01);
                bus(1'b1, 1'b0, ADDR_MEAS_SEL, d);
                idle(1);
                wait_ready();
                idle(1);
                chk(irq_request, !load_ready_irq_block);
                rd(ADDR_RES_HIGH, {6'h00, 2'(sum >> 8)});
                rd(ADDR_RES_LOW, 8'(sum));
                rd(ADDR_MEAS_SEL, d);
                irq_flag_clear <= 5'h10;
                idle(1);
                irq_flag_clear <= 5'h00;
                idle(20);
                chk(irq_flags[FLG_LOAD_READY], 1'b0);
            end
        end
        $display("load meter test done");
        idle(5);
        chk(exp_q.size(), 0);
        report_and_stop();
    end
endmodule // regulator_mask_load_meter_pg_select_bench
`default_nettype wire

// ===== sim/rmlm_sensor_model.sv
// sensor model answering sample requests, promptly or after a stall
`default_nettype none
module rmlm_sensor (
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        sense_req,
    input wire logic [1:0]  sense_idx,
    input wire logic [39:0] cur_flat,
    input wire logic        slow,
    output logic            sense_ack,
    output logic [9:0]      sense_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_ff;
    logic       busy_ff;
    logic [9:0] val_ff;
    // data churns outside the ack so a late capture is caught
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_ff    <= 1'b0;
            wait_ff    <= 3'h0;
            val_ff     <= 10'h000;
            sense_ack  <= 1'b0;
            sense_data <= 10'h000;
        end else if (busy_ff && wait_ff == 3'h0) begin
            busy_ff    <= 1'b0;
            sense_ack  <= 1'b1;
            sense_data <= val_ff;
        end else begin
            sense_ack  <= 1'b0;
            sense_data <= ~sense_data;
            if (busy_ff) wait_ff <= wait_ff - 3'h1;
            else if (sense_req) begin
                busy_ff <= 1'b1;
                wait_ff <= slow ? 3'h5 : 3'h0;
                val_ff  <= cur_flat[10*sense_idx +: 10];
            end
        end
    end
endmodule // rmlm_sensor
`default_nettype wire

// ===== sim/rmlm_top_chk.sv
// assertions on the ports of the regulator mask / load meter block
`default_nettype none
module rmlm_chk (
    input wire logic       core_clk,
    input wire logic       arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic [3:0] reg_good_raw,
    input wire logic [3:0] reg_limit_raw,
    input wire logic [7:0] phase_master_of,
    input wire logic       load_ready_irq_block,
    input wire logic [4:0] irq_flag_clear,
    input wire logic [4:0] irq_flags,
    input wire logic       irq_request,
    input wire logic       combined_power_ok_output,
    input wire logic       sense_req,
    input wire logic [1:0] sense_idx,
    input wire logic       sense_ack,
    input wire logic [9:0] sense_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import rmlm_pkg::*;
    logic [7:0] mask_ff, src_ff, sel_ff;
    logic       out_ff, pok_exp, irq_exp, idx_ok, sel_wr;
    // shadow copies of the writable registers, so reads and gating can be judged
    assign sel_wr = reg_wr && reg_addr == ADDR_MEAS_SEL;
    assign irq_exp = |(irq_flags & ~{load_ready_irq_block, mask_ff[6], mask_ff[4], mask_ff[2], mask_ff[0]});
    assign idx_ok = sense_idx == sel_ff[1:0] || (phase_master_of[2*sel_ff[1:0] +: 2] == sel_ff[1:0]
                    && phase_master_of[2*sense_idx +: 2] == sel_ff[1:0]);
    always_comb begin
        pok_exp = 1'b1;
        for (int i = 0; i < NUM_REG; i++) begin
            pok_exp &= (src_ff[2*i +: 2] == PG_SRC_OFF)
                | (reg_good_raw[i] & (src_ff[2*i +: 2] != PG_SRC_VOLT_ILIM | ~reg_limit_raw[i]));
        end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_ff <= MASK_2_3_RST;
            src_ff  <= PG_SRC_RST;
            sel_ff  <= MEAS_SEL_RST;
            out_ff  <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == ADDR_MASK_2_3) mask_ff <= reg_wdata & MASK_2_3_WR_BITS;
            if (reg_wr && reg_addr == ADDR_PG_SRC) src_ff <= reg_wdata;
            if (sel_wr) sel_ff <= reg_wdata;
            // a select write abandons any sample still owed
            out_ff <= !sel_wr && (sense_req || (out_ff && !sense_ack));
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence s_sel_wr; sel_wr; endsequence
    sequence s_rd(a); reg_rd && !reg_wr && reg_addr == a; endsequence
    property p_rvalid; reg_rvalid == $past(reg_rd); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read valid misplaced");
    property p_mask_rd; s_rd(ADDR_MASK_2_3) |=> reg_rdata == mask_ff; endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("mask read wrong");
    property p_res_high; s_rd(ADDR_RES_HIGH) |=> reg_rdata[7:2] == 6'h00; endproperty
    a_res_high: assert property (p_res_high) else $error("result high upper bits set");
    property p_limit_flag; $rose(reg_limit_raw[REG2]) |-> ##[1:2] irq_flags[FLG_REG2_LIMIT]; endproperty
    a_limit_flag: assert property (p_limit_flag) else $error("limit flag missing");
    property p_irq; $stable(mask_ff) && $stable(load_ready_irq_block) |-> irq_request == irq_exp; endproperty
    a_irq: assert property (p_irq) else $error("irq request wrong");
    property p_pok; 1'b1 |=> combined_power_ok_output == $past(pok_exp); endproperty
    a_pok: assert property (p_pok) else $error("power ok wrong");
    property p_one_out; sense_req |-> !out_ff; endproperty
    a_one_out: assert property (p_one_out) else $error("second sample request");
    property p_idx; sense_req |-> idx_ok; endproperty
    a_idx: assert property (p_idx) else $error("sample of excluded phase");
    property p_no_early; s_sel_wr |=> (!$rose(irq_flags[FLG_LOAD_READY])) [*3]; endproperty
    a_no_early: assert property (p_no_early) else $error("ready too early");
endmodule // rmlm_chk
bind rmlm_top rmlm_chk u_chk (.*);
`default_nettype wire
